// ### pkg/amp_i2c_map.svh
`ifndef AMP_I2C_MAP_SVH
`define AMP_I2C_MAP_SVH

// Fixed upper six bits of the seven-bit target address.
`define AMP_ADDR_HI      6'h36
// Register offsets.
`define REG_ID_OFS       8'h00
`define REG_PWR_OFS      8'h01
// Reset value of the power and clip register.
`define PWR_RESET        8'hfd
// Field positions of the power and clip register.
`define PWR_SD_BIT       0
`define PWR_SLEEP_BIT    1
`define PWR_CLIP_LSB     2
`define PWR_CLIP_MSB     7
// Cycles after reset release before the strap is latched.
`define STRAP_SETTLE     2'h3
// Byte width on the bus and last bit index inside a byte.
`define BYTE_BITS        8
`define BIT_LAST         3'h7

`endif

// ### pkg/amp_i2c_pkg.sv
package amp_i2c_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_ACK    = 3'b010,
    ST_TX     = 3'b011,
    ST_MACK   = 3'b100,
    ST_IGNORE = 3'b101
  } port_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_REG  = 2'b01,
    PH_DATA = 2'b10
  } byte_phase_t;

  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] rdata;
  } regs_state_t;

endpackage

// ### tb/amp_i2c_control_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module amp_i2c_port_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       sleep_or_addr_strap_pin,
  input wire logic       amp_low_power_hold,
  input wire logic       amp_power_down,
  input wire logic [5:0] clip_level_high
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [7:0] held_r;
  // Counts how long the device keeps pulling the data line low.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !sda_oe) held_r <= 8'h00;
    else if (held_r != 8'hff) held_r <= held_r + 8'h01;
  end
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data output value not low");
  AST_RST_DEFAULTS: assert property ($fell(sys_rst) |->
    {clip_level_high, amp_low_power_hold, amp_power_down} == 8'hfd)
    else $error("register outputs not at defaults after reset");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !sda_oe [*8])
    else $error("data line pulled right after reset");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |->
    !scl_in && !$past(scl_in))
    else $error("data line changed while clock high");
  AST_ACK_HOLD: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("data line released while clock high");
  AST_OE_AFTER_FALL: assert property ($rose(sda_oe) |->
    !$past(scl_in) && $past(scl_in, 6))
    else $error("data line pulled away from a clock fall");
  AST_REG_UPDATE: assert property (
    $changed({clip_level_high, amp_low_power_hold, amp_power_down}) |->
    !scl_in && !$past(scl_in))
    else $error("register outputs changed outside a byte end");
  AST_HOLD_BOUND: assert property (held_r < 8'hc8)
    else $error("data line held low too long");
endmodule
bind amp_i2c_control_port amp_i2c_port_checker u_amp_i2c_port_checker (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .sleep_or_addr_strap_pin(sleep_or_addr_strap_pin),
  .amp_low_power_hold(amp_low_power_hold), .amp_power_down(amp_power_down),
  .clip_level_high(clip_level_high));
`default_nettype wire

// ### tb/amp_i2c_control_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module amp_i2c_control_port_tb_top;
  logic       clk_sys;
  logic       sys_rst;
  logic       strap;
  logic       scl_low;
  logic       sda_low;
  logic       sda_oe;
  logic       hold;
  logic       pdn;
  logic [5:0] clip;
  logic [6:0] dev;
  int         miscompares;
  int         check_count;
  wire        scl_line = ~scl_low;
  wire        sda_line = ~(sda_low | sda_oe);
  amp_i2c_control_port u_amp_i2c_control_port (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl_line),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .sleep_or_addr_strap_pin(strap), .amp_low_power_hold(hold),
    .amp_power_down(pdn), .clip_level_high(clip));
  i2c_ctrl_model u_i2c_ctrl_model (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl_low(scl_low), .sda_low(sda_low));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic txc(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_i2c_ctrl_model.tx(d, a);
    chk({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_i2c_ctrl_model.start();
    txc({dev, 1'b0}, 1'b1);
    txc(ofs, 1'b1);
    txc(d, 1'b1);
    u_i2c_ctrl_model.stop();
  endtask
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] v;
    u_i2c_ctrl_model.start();
    txc({dev, 1'b0}, 1'b1);
    txc(ofs, 1'b1);
    u_i2c_ctrl_model.start();
    txc({dev, 1'b1}, 1'b1);
    u_i2c_ctrl_model.rx(v, 1'b1);
    u_i2c_ctrl_model.stop();
    chk(v, exp);
  endtask
  task automatic probe(input logic [6:0] a, input logic exp_ack);
    u_i2c_ctrl_model.start();
    txc({a, 1'b0}, exp_ack);
    u_i2c_ctrl_model.stop();
  endtask
  task automatic do_reset(input logic s);
    sys_rst <= 1'b1;
    strap <= s;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    strap = 1'b0;
    miscompares = 0;
    check_count = 0;
    dev = 7'h6c;
    do_reset(1'b0);
    chk({clip, hold, pdn}, 8'hfd);
    rd(8'h01, 8'hfd);
    rd(8'h00, 8'h5a);
    probe(7'h6d, 1'b0);
    probe(7'h6c, 1'b1);
    $display("test reset_and_address done");
    wr(8'h01, 8'hab);
    chk({clip, hold, pdn}, 8'hab);
    rd(8'h01, 8'hab);
    wr(8'h00, 8'h33);
    rd(8'h00, 8'h5a);
    $display("test write_read done");
    u_i2c_ctrl_model.start();
    txc({dev, 1'b0}, 1'b1);
    txc(8'h01, 1'b1);
    txc(8'h5c, 1'b1);
    txc(8'h77, 1'b1);
    txc(8'h99, 1'b1);
    u_i2c_ctrl_model.stop();
    chk({clip, hold, pdn}, 8'h5c);
    rd(8'h01, 8'h5c);
    $display("test long_write done");
    dev = 7'h6d;
    do_reset(1'b1);
    chk({clip, hold, pdn}, 8'hfd);
    probe(7'h6c, 1'b0);
    rd(8'h01, 8'hfd);
    $display("test strap_high done");
    summarize();
  end
endmodule
`default_nettype wire

// ### tb/i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  // Lines are only pulled low or released.
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Ten-cycle clock phases keep the bus at 5 MHz scale timing.
  task automatic put(input logic b);
    sda_low <= ~b;
    w(5);
    scl_low <= 1'b0;
    w(10);
    scl_low <= 1'b1;
    w(5);
  endtask
  task automatic get(output logic b);
    sda_low <= 1'b0;
    w(5);
    scl_low <= 1'b0;
    w(5);
    b = sda_line;
    w(5);
    scl_low <= 1'b1;
    w(5);
  endtask
  task automatic start;
    sda_low <= 1'b0;
    w(5);
    scl_low <= 1'b0;
    w(10);
    sda_low <= 1'b1;
    w(10);
    scl_low <= 1'b1;
    w(5);
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    w(5);
    scl_low <= 1'b0;
    w(10);
    sda_low <= 1'b0;
    w(10);
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(b);
    ack = ~b;
  endtask
  task automatic rx(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
endmodule
`default_nettype wire

// ### verilog/amp_i2c_control_port.sv
`timescale 1ns/1ps
`default_nettype none

`include "amp_i2c_map.svh"

module amp_i2c_control_port #(
  // Identification value is arbitrary.
  parameter logic [7:0] PART_ID = 8'h5a
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       sleep_or_addr_strap_pin,
  output logic            amp_low_power_hold,
  output logic            amp_power_down,
  output logic      [5:0] clip_level_high
);

  typedef struct packed {
    logic [1:0]                 strap_cnt;
    logic                       strap_done;
    logic                       addr_lsb;
    logic                       scl_q;
    logic                       sda_q;
    amp_i2c_pkg::port_state_t   state;
    amp_i2c_pkg::byte_phase_t   phase;
    logic [7:0]                 shift;
    logic [2:0]                 cnt;
    logic                       byte_full;
    logic                       rw;
    logic [7:0]                 ptr;
    logic                       oe;
    logic                       wr_en;
    logic                       mack_ok;
  } port_st_t;

  port_st_t   st_r;
  port_st_t   st_nxt;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic [7:0] rd_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       addr_hit;

  // Both bus lines and the strap come from outside the clock domain.
  // Two cycles of lag stay far below a 400 kHz half period.
  bit_sync #(
    .W       (3),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .d       ({scl_in, sda_in, sleep_or_addr_strap_pin}),
    .q       ({scl_s, sda_s, strap_s})
  );

  amp_reg_file #(
    .PART_ID (PART_ID)
  ) u_regs (
    .clk_sys            (clk_sys),
    .sys_rst            (sys_rst),
    .wr_en              (st_r.wr_en),
    .reg_addr           (st_r.ptr),
    .wr_data            (st_r.shift),
    .rd_data            (rd_data),
    .amp_low_power_hold (amp_low_power_hold),
    .amp_power_down     (amp_power_down),
    .clip_level_high    (clip_level_high)
  );

  // Edges are taken between two synchronised samples, never on the first stage.
  assign scl_rise   = scl_s & ~st_r.scl_q;
  assign scl_fall   = ~scl_s & st_r.scl_q;
  assign start_seen = scl_s & st_r.scl_q & st_r.sda_q & ~sda_s;
  assign stop_seen  = scl_s & st_r.scl_q & ~st_r.sda_q & sda_s;
  // Address compare against the fixed prefix plus the latched strap bit.
  assign addr_hit   = st_r.shift[7:1] == {`AMP_ADDR_HI, st_r.addr_lsb};

  always_comb begin
    st_nxt       = st_r;
    st_nxt.wr_en = 1'b0;
    st_nxt.scl_q = scl_s;
    st_nxt.sda_q = sda_s;

    if (!st_r.strap_done) begin
      // Wait for the synchroniser to carry the strap, then latch it once.
      if (st_r.strap_cnt == `STRAP_SETTLE) begin
        st_nxt.strap_done = 1'b1;
        st_nxt.addr_lsb   = strap_s;
      end else begin
        st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
      end
    end else if (start_seen) begin
      // A repeated START restarts address reception from any state.
      st_nxt.state     = amp_i2c_pkg::ST_RX;
      st_nxt.phase     = amp_i2c_pkg::PH_ADDR;
      st_nxt.cnt       = 3'h0;
      st_nxt.byte_full = 1'b0;
      st_nxt.mack_ok   = 1'b0;
      st_nxt.oe        = 1'b0;
    end else if (stop_seen) begin
      st_nxt.state     = amp_i2c_pkg::ST_IDLE;
      st_nxt.byte_full = 1'b0;
      st_nxt.mack_ok   = 1'b0;
      st_nxt.oe        = 1'b0;
    end else begin
      case (st_r.state)
        amp_i2c_pkg::ST_RX: begin
          if (scl_rise) begin
            // Data bits are sampled while SCL is high, MSB first.
            st_nxt.shift = {st_r.shift[6:0], sda_s};
            st_nxt.cnt   = st_r.cnt + 3'h1;
            if (st_r.cnt == `BIT_LAST) begin
              st_nxt.byte_full = 1'b1;
            end
          end else if (scl_fall && st_r.byte_full) begin
            st_nxt.byte_full = 1'b0;
            case (st_r.phase)
              amp_i2c_pkg::PH_ADDR: begin
                if (addr_hit) begin
                  st_nxt.rw    = st_r.shift[0];
                  st_nxt.state = amp_i2c_pkg::ST_ACK;
                  st_nxt.oe    = 1'b1;
                end else begin
                  st_nxt.state = amp_i2c_pkg::ST_IGNORE;
                end
              end
              amp_i2c_pkg::PH_REG: begin
                st_nxt.ptr   = st_r.shift;
                st_nxt.state = amp_i2c_pkg::ST_ACK;
                st_nxt.oe    = 1'b1;
              end
              default: begin
                // Register write uses the offset and the byte now held.
                st_nxt.wr_en = 1'b1;
                st_nxt.state = amp_i2c_pkg::ST_ACK;
                st_nxt.oe    = 1'b1;
              end
            endcase
          end
        end
        amp_i2c_pkg::ST_ACK: begin
          // Release only after the ninth clock has fallen.
          if (scl_fall) begin
            st_nxt.cnt = 3'h0;
            if (st_r.phase == amp_i2c_pkg::PH_ADDR && st_r.rw) begin
              st_nxt.state = amp_i2c_pkg::ST_TX;
              st_nxt.shift = rd_data;
              st_nxt.oe    = ~rd_data[7];
            end else begin
              st_nxt.state = amp_i2c_pkg::ST_RX;
              st_nxt.oe    = 1'b0;
              if (st_r.phase == amp_i2c_pkg::PH_ADDR) begin
                st_nxt.phase = amp_i2c_pkg::PH_REG;
              end else if (st_r.phase == amp_i2c_pkg::PH_REG) begin
                st_nxt.phase = amp_i2c_pkg::PH_DATA;
              end else begin
                // Further data bytes go to the following offset.
                st_nxt.ptr = st_r.ptr + 8'h01;
              end
            end
          end
        end
        amp_i2c_pkg::ST_TX: begin
          if (scl_rise) begin
            st_nxt.cnt = st_r.cnt + 3'h1;
            if (st_r.cnt == `BIT_LAST) begin
              st_nxt.byte_full = 1'b1;
            end
          end else if (scl_fall) begin
            // The next bit is presented only after SCL has gone low.
            if (st_r.byte_full) begin
              st_nxt.byte_full = 1'b0;
              st_nxt.state     = amp_i2c_pkg::ST_MACK;
              st_nxt.oe        = 1'b0;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.oe    = ~st_r.shift[6];
            end
          end
        end
        amp_i2c_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              // Not-acknowledge: stay off the bus until STOP or START.
              st_nxt.state = amp_i2c_pkg::ST_IGNORE;
            end else begin
              st_nxt.ptr     = st_r.ptr + 8'h01;
              st_nxt.mack_ok = 1'b1;
            end
          end else if (scl_fall && st_r.mack_ok) begin
            // Register data has settled for the new offset by this edge.
            st_nxt.mack_ok = 1'b0;
            st_nxt.cnt     = 3'h0;
            st_nxt.state   = amp_i2c_pkg::ST_TX;
            st_nxt.shift   = rd_data;
            st_nxt.oe      = ~rd_data[7];
          end
        end
        amp_i2c_pkg::ST_IGNORE: begin
          st_nxt.oe = 1'b0;
        end
        default: begin
          st_nxt.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r.strap_cnt  <= 2'h0;
      st_r.strap_done <= 1'b0;
      st_r.addr_lsb   <= 1'b0;
      st_r.scl_q      <= 1'b1;
      st_r.sda_q      <= 1'b1;
      st_r.state      <= amp_i2c_pkg::ST_IDLE;
      st_r.phase      <= amp_i2c_pkg::PH_ADDR;
      st_r.shift      <= 8'h00;
      st_r.cnt        <= 3'h0;
      st_r.byte_full  <= 1'b0;
      st_r.rw         <= 1'b0;
      st_r.ptr        <= 8'h00;
      st_r.oe         <= 1'b0;
      st_r.wr_en      <= 1'b0;
      st_r.mack_ok    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // SDA is only ever pulled low; SCL is never driven, so no clock stretch.
  assign sda_out = 1'b0;
  assign sda_oe  = st_r.oe;

endmodule

`default_nettype wire

// ### verilog/amp_reg_file.sv
`timescale 1ns/1ps
`default_nettype none

`include "amp_i2c_map.svh"

module amp_reg_file #(
  // Identification value is arbitrary.
  parameter logic [7:0] PART_ID = 8'h5a
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            amp_low_power_hold,
  output logic            amp_power_down,
  output logic      [5:0] clip_level_high
);

  amp_i2c_pkg::regs_state_t st_r;
  amp_i2c_pkg::regs_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // The identification register ignores writes; unmapped offsets too.
    if (wr_en && reg_addr == `REG_PWR_OFS) begin
      st_nxt.pwr = wr_data;
    end
    case (reg_addr)
      `REG_ID_OFS:  st_nxt.rdata = PART_ID;
      `REG_PWR_OFS: st_nxt.rdata = st_r.pwr;
      default:      st_nxt.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r.pwr   <= `PWR_RESET;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data            = st_r.rdata;
  assign amp_low_power_hold = st_r.pwr[`PWR_SLEEP_BIT];
  assign amp_power_down     = st_r.pwr[`PWR_SD_BIT];
  assign clip_level_high    = st_r.pwr[`PWR_CLIP_MSB:`PWR_CLIP_LSB];

endmodule

`default_nettype wire

// ### verilog/bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= {(2 * W){RST_VAL}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

`default_nettype wire
